// ==== scbl_top.sv ====
// serial channel 0 with baud generator, error checks and boot loader
`timescale 1ns/1ps
// Behaviour
// - async full duplex up to 625 Kbaud
// - sync half duplex up to 2.5 Mbaud
// - own programmable baud generator from clock
// - separate transmit, receive, error events
// - start, 8/9 data, one or two stops
// - wake bit marks address bytes, filterable
// - sync shifts one byte, own shift clock
// - loopback routes transmit into receiver
// - parity generated on send, checked on receive
// - missing stop bit flags framing error
// - unread buffer on new character flags overrun
// - boot entry: strap high, then NMI low
// - entry ignores bus configuration pins
// - time zero byte, program channel baud
// - send one acknowledge byte after calibration
// - store next 32 bytes at ascending RAM
// - jump to first loaded location afterwards
// - software reset or hardware reset with strap low ends boot
module scbl_top #(
  parameter int LOAD_N = scbl_pkg::LOAD_BYTES,
  parameter int MEAS_W = 24
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sw_rst,
  input wire logic i_ale_strap,
  input wire logic i_nmi_n,
  input wire scbl_pkg::scbl_cfg_s i_cfg,
  input wire logic i_rxd,
  input wire logic i_tx_valid,
  input wire logic [8:0] i_tx_data,
  input wire logic i_rx_read,
  input wire logic i_sync_rx_start,
  input wire logic i_err_clr,
  output logic o_txd,
  output logic o_sclk,
  output logic o_tx_busy,
  output logic o_tx_done,
  output logic o_rx_done,
  output logic o_err_event,
  output logic [8:0] o_rx_data,
  output logic o_rx_full,
  output scbl_pkg::scbl_err_s o_err,
  output logic o_boot_mode,
  output logic o_mem_we,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_data,
  output logic o_jump,
  output logic [15:0] o_jump_addr
);
  import scbl_pkg::*;
  localparam int CNT_W = $clog2(LOAD_N);
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_NINTH = 3'b011, TX_STOP = 3'b100, TX_SYNC = 3'b101
  } scbl_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_NINTH = 3'b011, RX_STOP = 3'b100
  } scbl_rx_e;
  typedef enum logic [2:0] {
    B_OFF = 3'b000, B_WAIT = 3'b001, B_MEAS = 3'b010, B_CALC = 3'b011,
    B_ACK = 3'b100, B_ACKW = 3'b101, B_LOAD = 3'b110, B_RUN = 3'b111
  } scbl_boot_e;

  logic ch_rst;
  logic rst_d, strap_chk, strap_ale;
  scbl_boot_e boot_st;
  logic boot_hold, ack_req, user_req, boot_take, rx_allow;
  logic [RELOAD_W-1:0] boot_reload;
  logic [MEAS_W-1:0] meas, meas_div;
  logic [CNT_W-1:0] load_cnt;
  logic load_last;
  scbl_cfg_s cfg;
  logic [RELOAD_W-1:0] baud_cnt;
  logic tick, rx_line, rx_prev, ninth_en;
  scbl_tx_e tx_st;
  logic [8:0] tx_sh;
  logic [3:0] tx_sub;
  logic [2:0] tx_bit;
  logic tx_nin, tx_stop2, sync_rx, sync_fin;
  scbl_rx_e rx_st;
  logic [8:0] rx_sh;
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  logic rx_fin, rx_stop;
  logic rx_keep, par_bad, frm_bad, ovr_bad, new_char;

  assign ch_rst = i_rst || i_sw_rst;

  // ********************
  // boot entry straps
  // ********************
  // strap is caught one edge after release, nmi the edge after that
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rst_d <= 1'b1;
      strap_chk <= 1'b0;
      strap_ale <= 1'b0;
    end else begin
      rst_d <= 1'b0;
      strap_chk <= rst_d;
      if (rst_d) begin
        strap_ale <= i_ale_strap;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_boot_mode <= 1'b0;
    end else if (i_sw_rst) begin
      o_boot_mode <= 1'b0;
    end else if (strap_chk && strap_ale && !i_nmi_n) begin
      o_boot_mode <= 1'b1;
    end
  end

  // ********************
  // effective configuration
  // ********************
  assign boot_hold = o_boot_mode && (boot_st != B_RUN);
  always_comb begin
    cfg = i_cfg;
    if (boot_hold) begin
      cfg.mode = MODE_ASYNC8;
      cfg.two_stop = 1'b0;
      cfg.par_en = 1'b0;
      cfg.loopback = 1'b0;
      cfg.addr_only = 1'b0;
      cfg.reload = boot_reload;
    end
    // faster settings are clamped to the rated ceiling
    if (cfg.mode == MODE_SYNC && cfg.reload < SYNC_MIN_RELOAD) begin
      cfg.reload = SYNC_MIN_RELOAD;
    end else if (cfg.mode != MODE_SYNC && cfg.reload < ASYNC_MIN_RELOAD) begin
      cfg.reload = ASYNC_MIN_RELOAD;
    end
  end

  assign ninth_en = (cfg.mode != MODE_SYNC) && ((cfg.mode != MODE_ASYNC8) || cfg.par_en);
  assign rx_line = cfg.loopback ? o_txd : i_rxd;

  // ********************
  // baud generator
  // ********************
  // async uses 16 ticks a bit, sync one tick a half period
  always_ff @(posedge i_sys_clk) begin
    if (ch_rst) begin
      baud_cnt <= RELOAD_RST;
      tick <= 1'b0;
    end else if (baud_cnt == RELOAD_RST) begin
      baud_cnt <= cfg.reload;
      tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt - 1'b1;
      tick <= 1'b0;
    end
  end

  // ********************
  // transmitter and sync shifter
  // ********************
  assign ack_req = (boot_st == B_ACK);
  assign user_req = i_tx_valid && !boot_hold;
  always_ff @(posedge i_sys_clk) begin
    o_tx_done <= 1'b0;
    sync_fin <= 1'b0;
    if (ch_rst) begin
      tx_st <= TX_IDLE;
      o_txd <= 1'b1;
      o_sclk <= 1'b1;
      o_tx_busy <= 1'b0;
      tx_sh <= 9'h000;
      tx_sub <= 4'h0;
      tx_bit <= 3'h0;
      tx_nin <= 1'b0;
      tx_stop2 <= 1'b0;
      sync_rx <= 1'b0;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          tx_sub <= 4'h0;
          tx_bit <= 3'h0;
          tx_stop2 <= 1'b0;
          if (ack_req || user_req) begin
            tx_sh <= ack_req ? {1'b0, ACK_BYTE} : i_tx_data;
            tx_nin <= (cfg.mode == MODE_ASYNC8) ? (^i_tx_data[7:0] ^ cfg.par_odd) : i_tx_data[8];
            o_tx_busy <= 1'b1;
            sync_rx <= 1'b0;
            if (cfg.mode == MODE_SYNC) begin
              tx_st <= TX_SYNC;
            end else begin
              o_txd <= 1'b0;
              tx_st <= TX_START;
            end
          end else if (cfg.mode == MODE_SYNC && i_sync_rx_start) begin
            tx_sh <= 9'h1FF;
            sync_rx <= 1'b1;
            o_tx_busy <= 1'b1;
            tx_st <= TX_SYNC;
          end
        end
        TX_SYNC: if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          // extra half period: last bit must stand past the final rising clock
          if (tx_bit != 3'h0) begin
            tx_st <= TX_IDLE;
            o_tx_busy <= 1'b0;
            o_txd <= 1'b1;
            o_tx_done <= !sync_rx;
            sync_fin <= sync_rx;
          end else if (!tx_sub[0]) begin
            o_sclk <= 1'b0;
            o_txd <= sync_rx ? 1'b1 : tx_sh[0];
          end else begin
            o_sclk <= 1'b1;
            tx_sh <= {rx_line, tx_sh[8:1]};
            if (tx_sub == SUB_LAST) begin
              tx_bit <= 3'h1;
            end
          end
        end
        TX_START, TX_DATA, TX_NINTH, TX_STOP: if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          if (tx_sub == SUB_LAST) begin
            case (tx_st)
              TX_START: begin
                o_txd <= tx_sh[0];
                tx_st <= TX_DATA;
              end
              TX_DATA: begin
                tx_bit <= tx_bit + 3'h1;
                tx_sh <= {1'b0, tx_sh[8:1]};
                if (tx_bit != BIT_LAST) begin
                  o_txd <= tx_sh[1];
                end else if (ninth_en) begin
                  o_txd <= tx_nin;
                  tx_st <= TX_NINTH;
                end else begin
                  o_txd <= 1'b1;
                  tx_st <= TX_STOP;
                end
              end
              TX_NINTH: begin
                o_txd <= 1'b1;
                tx_st <= TX_STOP;
              end
              default: begin
                if (cfg.two_stop && !tx_stop2) begin
                  tx_stop2 <= 1'b1;
                end else begin
                  tx_st <= TX_IDLE;
                  o_tx_busy <= 1'b0;
                  o_tx_done <= 1'b1;
                end
              end
            endcase
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // ********************
  // async receiver
  // ********************
  // receiver is held off while the boot loader calibrates
  assign rx_allow = !boot_hold || (boot_st == B_LOAD);
  always_ff @(posedge i_sys_clk) begin
    rx_fin <= 1'b0;
    if (ch_rst) begin
      rx_st <= RX_IDLE;
      rx_prev <= 1'b1;
      rx_sh <= 9'h000;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_stop <= 1'b1;
    end else begin
      rx_prev <= rx_line;
      case (rx_st)
        RX_IDLE: begin
          rx_sub <= 4'h0;
          rx_bit <= 3'h0;
          if (cfg.mode != MODE_SYNC && rx_allow && rx_prev && !rx_line) begin
            rx_sh <= 9'h000;
            rx_st <= RX_START;
          end
        end
        RX_START: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == SUB_MID) begin
            rx_sub <= 4'h0;
            rx_st <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA, RX_NINTH, RX_STOP: if (tick) begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == SUB_LAST) begin
            case (rx_st)
              RX_DATA: begin
                rx_sh[rx_bit] <= rx_line;
                rx_bit <= rx_bit + 3'h1;
                if (rx_bit == BIT_LAST) begin
                  rx_st <= ninth_en ? RX_NINTH : RX_STOP;
                end
              end
              RX_NINTH: begin
                rx_sh[8] <= rx_line;
                rx_st <= RX_STOP;
              end
              default: begin
                rx_stop <= rx_line;
                rx_fin <= 1'b1;
                rx_st <= RX_IDLE;
              end
            endcase
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // ********************
  // receive buffer, errors, events
  // ********************
  assign rx_keep = (cfg.mode != MODE_WAKE) || !cfg.addr_only || rx_sh[8];
  assign par_bad = (cfg.mode == MODE_ASYNC8) && cfg.par_en && (^rx_sh ^ cfg.par_odd);
  assign frm_bad = cfg.frm_chk && !rx_stop;
  assign new_char = (rx_fin && rx_keep) || sync_fin;
  assign boot_take = (boot_st == B_LOAD) && o_rx_done;
  assign ovr_bad = cfg.ovr_chk && o_rx_full && !i_rx_read && !boot_take;
  // errors flag and set wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (ch_rst) begin
      o_rx_data <= 9'h000;
      o_rx_full <= 1'b0;
      o_rx_done <= 1'b0;
      o_err_event <= 1'b0;
      o_err <= '0;
    end else begin
      o_rx_done <= new_char;
      o_err_event <= new_char && (ovr_bad || (rx_fin && (par_bad || frm_bad)));
      o_rx_full <= (o_rx_full && !i_rx_read && !boot_take) || new_char;
      if (new_char) begin
        o_rx_data <= sync_fin ? {1'b0, tx_sh[8:1]} : rx_sh;
      end
      o_err.par <= (o_err.par && !i_err_clr) || (rx_fin && rx_keep && par_bad);
      o_err.frm <= (o_err.frm && !i_err_clr) || (rx_fin && rx_keep && frm_bad);
      o_err.ovr <= (o_err.ovr && !i_err_clr) || (new_char && ovr_bad);
    end
  end

  // ********************
  // boot loader sequence
  // ********************
  assign meas_div = meas / MEAS_W'(MEAS_DIV);
  assign load_last = (load_cnt == CNT_W'(LOAD_N - 1));
  always_ff @(posedge i_sys_clk) begin
    o_mem_we <= 1'b0;
    o_jump <= 1'b0;
    if (ch_rst) begin
      boot_st <= B_OFF;
      meas <= '0;
      boot_reload <= RELOAD_RST;
      load_cnt <= '0;
      o_mem_addr <= LOAD_BASE;
      o_mem_data <= 8'h00;
      o_jump_addr <= 16'h0000;
    end else begin
      case (boot_st)
        B_OFF: if (o_boot_mode) begin
          boot_st <= B_WAIT;
        end
        B_WAIT: if (rx_prev && !i_rxd) begin
          meas <= MEAS_W'(1);
          boot_st <= B_MEAS;
        end
        B_MEAS: begin
          if (i_rxd) begin
            boot_st <= B_CALC;
          end else if (meas != '1) begin
            meas <= meas + 1'b1;
          end
        end
        B_CALC: begin
          // clock cycles per 16x tick, less one, saturating
          if (meas_div == '0) begin
            boot_reload <= RELOAD_RST;
          end else if (meas_div > MEAS_W'({RELOAD_W{1'b1}})) begin
            boot_reload <= '1;
          end else begin
            boot_reload <= RELOAD_W'(meas_div - 1'b1);
          end
          boot_st <= B_ACK;
        end
        B_ACK: if (tx_st == TX_IDLE) begin
          boot_st <= B_ACKW;
        end
        B_ACKW: if (o_tx_done) begin
          boot_st <= B_LOAD;
        end
        B_LOAD: if (o_rx_done) begin
          o_mem_we <= 1'b1;
          o_mem_data <= o_rx_data[7:0];
          o_mem_addr <= LOAD_BASE + 16'(load_cnt);
          load_cnt <= load_cnt + 1'b1;
          if (load_last) begin
            o_jump <= 1'b1;
            o_jump_addr <= LOAD_BASE;
            boot_st <= B_RUN;
          end
        end
        B_RUN: boot_st <= B_RUN;
        default: boot_st <= B_OFF;
      endcase
    end
  end
endmodule

// ==== scbl_pkg.sv ====
// shared constants and types of the serial channel with boot loader
package scbl_pkg;
  // ********************
  // timing
  // ********************
  localparam int CLK_HZ = 20_000_000;
  localparam int ASYNC_MAX_BAUD = 625_000;
  localparam int SYNC_MAX_BAUD = 2_500_000;
  localparam int OVERSAMPLE = 16;
  localparam int SYNC_HALVES = 2;
  localparam int RELOAD_W = 13;
  localparam logic [RELOAD_W-1:0] ASYNC_MIN_RELOAD = RELOAD_W'(CLK_HZ / (ASYNC_MAX_BAUD * OVERSAMPLE) - 1);
  localparam logic [RELOAD_W-1:0] SYNC_MIN_RELOAD = RELOAD_W'(CLK_HZ / (SYNC_MAX_BAUD * SYNC_HALVES) - 1);
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 13'h0000;
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ********************
  // boot loader
  // ********************
  localparam int ZERO_BITS = 9;
  localparam int MEAS_DIV = ZERO_BITS * OVERSAMPLE;
  localparam int LOAD_BYTES = 32;
  localparam logic [15:0] LOAD_BASE = 16'hFA40;
  localparam logic [7:0] ACK_BYTE = 8'hA5; // arbitrary value
  // ********************
  // types
  // ********************
  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_ASYNC8 = 2'b01,
    MODE_ASYNC9 = 2'b10,
    MODE_WAKE = 2'b11
  } scbl_mode_e;
  typedef struct packed {
    scbl_mode_e mode;
    logic two_stop;
    logic par_en;
    logic par_odd;
    logic frm_chk;
    logic ovr_chk;
    logic loopback;
    logic addr_only;
    logic [RELOAD_W-1:0] reload;
  } scbl_cfg_s;
  typedef struct packed {
    logic par;
    logic frm;
    logic ovr;
  } scbl_err_s;
endpackage

// ==== scbl_asserts.sv ====
// port checker for the serial channel with boot loader
`timescale 1ns/1ps
module scbl_asserts #(
  parameter int LOAD_N = scbl_pkg::LOAD_BYTES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sw_rst,
  input wire logic i_tx_valid,
  input wire scbl_pkg::scbl_cfg_s i_cfg,
  input wire logic o_txd,
  input wire logic o_sclk,
  input wire logic o_tx_busy,
  input wire logic o_tx_done,
  input wire logic o_rx_done,
  input wire logic o_err_event,
  input wire scbl_pkg::scbl_err_s o_err,
  input wire logic o_boot_mode,
  input wire logic o_mem_we,
  input wire logic [15:0] o_mem_addr,
  input wire logic o_jump,
  input wire logic [15:0] o_jump_addr
);
  import scbl_pkg::*;
  localparam logic [5:0] LAST = 6'(LOAD_N - 1);
  logic [5:0] n_wr;
  // ********************
  // helper
  // ********************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_sw_rst)
      n_wr <= 6'h00;
    else if (o_mem_we)
      n_wr <= n_wr + 6'h01;
  end
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || i_sw_rst);
  // done cycle excluded: whether a request is taken there is left open
  sequence s_take;
    !o_tx_busy && !o_tx_done && i_tx_valid && !o_boot_mode && i_cfg.mode != MODE_SYNC;
  endsequence
  sequence s_start;
    o_tx_busy && !o_txd;
  endsequence
  property p_start_bit;
    s_take |=> s_start;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit after request");
  property p_done;
    o_tx_done |-> !o_tx_busy && $past(o_tx_busy);
  endproperty
  a_done: assert property (p_done) else $error("done without busy end");
  property p_idle;
    !o_tx_busy |-> o_txd && o_sclk;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle high");
  property p_err;
    o_err_event |-> o_rx_done ##[0:1] (|o_err);
  endproperty
  a_err: assert property (p_err) else $error("error event alone");
  property p_mem_addr;
    o_mem_we |-> o_mem_addr == LOAD_BASE + {10'h000, n_wr};
  endproperty
  a_mem_addr: assert property (p_mem_addr) else $error("load address wrong");
  property p_jump;
    o_mem_we |-> o_jump == (n_wr == LAST);
  endproperty
  a_jump: assert property (p_jump) else $error("jump not with last store");
  property p_jump_addr;
    o_jump |=> o_jump_addr == LOAD_BASE;
  endproperty
  a_jump_addr: assert property (p_jump_addr) else $error("jump target wrong");
  property p_sw_exit;
    disable iff (i_rst) i_sw_rst |=> !o_boot_mode;
  endproperty
  a_sw_exit: assert property (p_sw_exit) else $error("boot mode kept");
endmodule
bind scbl_top scbl_asserts #(.LOAD_N(LOAD_N)) u_chk (.i_sys_clk, .i_rst, .i_sw_rst, .i_tx_valid, .i_cfg, .o_txd,
  .o_sclk, .o_tx_busy, .o_tx_done, .o_rx_done, .o_err_event, .o_err, .o_boot_mode, .o_mem_we, .o_mem_addr,
  .o_jump, .o_jump_addr);

// ==== scbl_host.sv ====
// behavioural host that downloads code through the boot loader
`timescale 1ns/1ps
module scbl_host #(
  parameter int BIT_CLKS = 65
) (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_dev_txd,
  input wire logic [7:0] i_code [32],
  output logic o_line,
  output logic [7:0] o_ack
);
  // ********************
  // frames
  // ********************
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_line <= f[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
  endtask
  // bit slightly long so a floor in the measurement cannot drop a step
  initial begin
    o_line = 1'b1;
    o_ack = 8'h00;
    wait (i_go === 1'b1);
    @(posedge i_clk);
    // acknowledge may start while our stop bit is still on the line
    fork
      send(8'h00);
      begin
        @(negedge i_dev_txd);
        repeat (BIT_CLKS / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS - 1) @(negedge i_clk);
          o_ack[i] = i_dev_txd;
        end
      end
    join
    // let the acknowledge stop bit pass before any code byte
    repeat (2 * BIT_CLKS) @(posedge i_clk);
    foreach (i_code[i])
      send(i_code[i]);
  end
endmodule

// ==== test_serial_channel_with_boot_loader.sv ====
// self-checking bench of the serial channel with boot loader
`timescale 1ns/1ps
module test_serial_channel_with_boot_loader;
  import scbl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sw_rst = 1'b0;
  logic strap = 1'b1;
  logic nmi_n = 1'b0;
  logic go = 1'b0;
  logic tx_valid = 1'b0;
  logic rx_read = 1'b0;
  logic err_clr = 1'b0;
  logic sync_rx = 1'b0;
  logic [8:0] tx_data = 9'h000;
  scbl_cfg_s cfg = '0;
  logic txd, sclk, tx_done, rx_done, boot, mem_we, jump, line, rx_full;
  logic [8:0] rx_data;
  logic [15:0] mem_addr, jump_addr;
  logic [7:0] mem_data, ack, sh;
  logic [7:0] code [32];
  scbl_err_s err;
  logic [8:0] got_q [$];
  int miscompares = 0;
  int n_compared = 0;
  int n_wr = 0;
  int n_tx = 0;
  always #25 clk = ~clk;
  scbl_top uut (.i_sys_clk(clk), .i_rst(rst), .i_sw_rst(sw_rst), .i_ale_strap(strap), .i_nmi_n(nmi_n),
    .i_cfg(cfg), .i_rxd(line), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_rx_read(rx_read),
    .i_sync_rx_start(sync_rx), .i_err_clr(err_clr), .o_txd(txd), .o_sclk(sclk), .o_tx_busy(), .o_tx_done(tx_done),
    .o_rx_done(rx_done), .o_err_event(), .o_rx_data(rx_data), .o_rx_full(rx_full), .o_err(err), .o_boot_mode(boot),
    .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_data(mem_data), .o_jump(jump), .o_jump_addr(jump_addr));
  scbl_host #(.BIT_CLKS(65)) host (.i_clk(clk), .i_go(go), .i_dev_txd(txd), .i_code(code), .o_line(line),
    .o_ack(ack));
  // ********************
  // compare and monitors
  // ********************
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge sclk) sh <= {txd, sh[7:1]};
  always @(posedge clk) begin
    if (rx_done === 1'b1)
      got_q.push_back(rx_data);
    if (tx_done === 1'b1)
      n_tx++;
    if (jump === 1'b1)
      check("jump slot", 16'(n_wr), 16'(LOAD_BYTES - 1));
    if (mem_we === 1'b1) begin
      check("mem addr", mem_addr, LOAD_BASE + 16'(n_wr));
      check("mem data", 16'(mem_data), 16'(code[n_wr[4:0]]));
      n_wr++;
    end
  end
  function automatic scbl_cfg_s mk(input scbl_mode_e m, input logic two, input logic odd, input logic ao);
    scbl_cfg_s c;
    c = '0;
    c.mode = m;
    c.two_stop = two;
    c.par_en = (m == MODE_ASYNC8);
    c.par_odd = odd;
    c.frm_chk = 1'b1;
    c.ovr_chk = 1'b1;
    c.loopback = (m != MODE_SYNC);
    c.addr_only = ao;
    c.reload = (m == MODE_SYNC) ? 13'h0003 : 13'h0001;
    return c;
  endfunction
  // one transmit, then the receiver queue against the expected character
  task automatic xfer(input scbl_cfg_s c, input logic [8:0] d, input int want, input logic rd);
    logic [8:0] e;
    int n0;
    e = d;
    n0 = n_tx;
    if (c.mode == MODE_ASYNC8)
      e[8] = ^d[7:0] ^ c.par_odd;
    @(posedge clk);
    cfg <= c;
    tx_data <= d;
    tx_valid <= 1'b1;
    @(posedge clk);
    tx_valid <= 1'b0;
    for (int k = 0; k < 4000 && n_tx == n0; k++)
      @(negedge clk);
    repeat (40) @(negedge clk);
    check("rx count", 16'(got_q.size()), 16'(want));
    if (got_q.size() > 0)
      check("rx data", 16'(got_q.pop_front()), 16'(e));
    got_q.delete();
    check("rx full", 16'(rx_full), 16'(want != 0));
    @(posedge clk);
    rx_read <= rd;
    @(posedge clk);
    rx_read <= 1'b0;
  endtask
  initial begin
    #(90000 * 50);
    miscompares++;
    close_out();
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    void'($urandom(38590));
    foreach (code[i])
      code[i] = 8'($urandom);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge clk);
    check("boot mode", 16'(boot), 16'h0001);
    @(posedge clk);
    go <= 1'b1;
    for (int k = 0; k < 40000 && n_wr < LOAD_BYTES; k++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    check("ack", 16'(ack), 16'(ACK_BYTE));
    check("loaded", 16'(n_wr), 16'(LOAD_BYTES));
    check("jump addr", jump_addr, LOAD_BASE);
    check("boot rx", 16'(got_q.size()), 16'(LOAD_BYTES));
    got_q.delete();
    @(posedge clk);
    sw_rst <= 1'b1;
    @(posedge clk);
    sw_rst <= 1'b0;
    @(negedge clk);
    check("boot exit", 16'(boot), 16'h0000);
    for (int i = 0; i < 4; i++)
      xfer(mk(i < 2 ? MODE_ASYNC8 : (i == 2 ? MODE_ASYNC9 : MODE_WAKE), i[0], i[1], 1'b0), 9'($urandom), 1, 1'b1);
    xfer(mk(MODE_WAKE, 1'b0, 1'b0, 1'b1), {1'b0, 8'($urandom)}, 0, 1'b1);
    xfer(mk(MODE_WAKE, 1'b0, 1'b0, 1'b1), {1'b1, 8'($urandom)}, 1, 1'b1);
    xfer(mk(MODE_ASYNC9, 1'b0, 1'b0, 1'b0), 9'h1AC, 1, 1'b0);
    xfer(mk(MODE_ASYNC9, 1'b0, 1'b0, 1'b0), 9'h053, 1, 1'b1);
    check("overrun", 16'(err), 16'h0001);
    @(posedge clk);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    @(negedge clk);
    check("err clear", 16'(err), 16'h0000);
    xfer(mk(MODE_SYNC, 1'b0, 1'b0, 1'b0), 9'h0C5, 0, 1'b0);
    check("sync out", 16'(sh), 16'h00C5);
    // sync receive of the idle-high host line gives all ones
    @(posedge clk);
    sync_rx <= 1'b1;
    @(posedge clk);
    sync_rx <= 1'b0;
    repeat (200) @(negedge clk);
    check("sync rx count", 16'(got_q.size()), 16'h0001);
    if (got_q.size() > 0)
      check("sync rx data", 16'(got_q.pop_front()), 16'h00FF);
    @(posedge clk);
    rst <= 1'b1;
    strap <= 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge clk);
    check("no boot", 16'(boot), 16'h0000);
    close_out();
  end
endmodule
